// *** src/fpru_top.sv ***
// Floating-point operand selection, moves and result rounding
`timescale 1ns/1ps
`default_nettype none
`include "fpru_consts.svh"

//------------------------------------------------------------
// Function
//------------------------------------------------------------
// Function
// - An inexact rounded result sets the inexact flag in the control word.
// - Rounding follows destination format and control-word rounding mode.
// - Round-up gives nearest value not below the exact result.
// - Round-down gives nearest value not above the exact result.
// - Truncate gives nearest value not larger in magnitude.
// - Nearest mode picks closest value, ties go to even lsb.
// - Positive overflow: up and nearest give +inf, others largest finite.
// - Negative overflow: down and nearest give -inf, others most negative finite.
// - Compares, exact results and NaN results are not affected by rounding.
// - Destinations narrower than the source operands are accepted.
// - Narrow results are rounded once, straight from the exact value.
// - All instructions decode from the shared three-operand register format.
// - Only +0.0 and +1.0 literals exist; other operands are registers.
// - Any global, local or fp register may be operand or destination.
// - Opcode picks real or long-real reading of general registers.
// - Extended fp registers mix with either precision variant.
// - Plain moves copy words unchanged; real moves convert to/from fp.
// - Copy-sign gives same or opposite sign when an fp register is used.
// - Any instruction with a real operand is routed through this unit.
module fpru_top (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Instruction issue
	input  wire logic         ins_valid,
	input  wire logic [31:0]  ins_word,
	output logic              ins_ready,
	output logic              ins_done,
	output logic              ins_bad,
	// Arithmetic hand-off
	output logic              op_start,
	output logic [3:0]        op_sub,
	output logic              op_long,
	output logic [79:0]       op_a,
	output logic [79:0]       op_b,
	// Exact result back
	input  wire logic         res_valid,
	input  wire logic         res_sgn,
	input  wire logic [16:0]  res_exp,
	input  wire logic [66:0]  res_sig,
	input  wire logic         res_nan,
	input  wire logic [2:0]   res_cc,
	// Arithmetic control word
	input  wire logic         ac_wr,
	input  wire logic [31:0]  ac_wdata,
	output logic [31:0]       ac
);
	//------------------------------------------------------------
	// Storage and decode
	//------------------------------------------------------------
	logic [31:0]             gen [0:31];
	logic [79:0]             fpr [0:3];
	fpru_pkg::fpru_state_t   st;
	fpru_pkg::fpru_src_t     w_kind;
	logic [4:0]              w_idx;
	fpru_pkg::fpru_fmt_t     w_fmt;
	logic                    w_cmp;

	logic [11:0]             key;
	logic                    long_op;
	logic                    arith_op;
	logic                    cmp_op;
	fpru_pkg::fpru_src_t     kind1;
	fpru_pkg::fpru_src_t     kind2;
	fpru_pkg::fpru_src_t     kindd;
	logic [4:0]              idx1;
	logic [4:0]              idx2;
	logic [4:0]              idxd;

	fpru_opdec u_dec (
		.ins_word (ins_word),
		.key      (key),
		.long_op  (long_op),
		.arith_op (arith_op),
		.cmp_op   (cmp_op),
		.kind1    (kind1),
		.kind2    (kind2),
		.kindd    (kindd),
		.idx1     (idx1),
		.idx2     (idx2),
		.idxd     (idxd)
	);

	// Words of one general-register operand, index wraps
	wire [4:0]  i1a  = idx1 + 5'h1;
	wire [4:0]  i1b  = idx1 + 5'h2;
	wire [4:0]  i2a  = idx2 + 5'h1;
	wire [4:0]  i2b  = idx2 + 5'h2;
	wire [95:0] raw1 = {gen[i1b], gen[i1a], gen[idx1]};
	wire [95:0] raw2 = {gen[i2b], gen[i2a], gen[idx2]};

	// Widen real or long real to extended; denormals keep their fraction under a zero exponent
	function automatic logic [79:0] widen(input logic [95:0] r, input fpru_pkg::fpru_fmt_t f);
		logic [7:0]  es;
		logic [10:0] el;
		es = r[30:23];
		el = r[62:52];
		case (f)
			fpru_pkg::FMT_REAL:
				widen = {r[31], es == 8'h00 ? 15'h0000 : es == 8'hff ? 15'h7fff : {7'h00, es} + `FPRU_RB_REAL,
					es != 8'h00, r[22:0], 40'h0};
			fpru_pkg::FMT_LONG:
				widen = {r[63], el == 11'h000 ? 15'h0000 : el == 11'h7ff ? 15'h7fff : {4'h0, el} + `FPRU_RB_LONG,
					el != 11'h000, r[51:0], 11'h0};
			default: widen = r[79:0];
		endcase
	endfunction

	// Operand value from its source kind; fp word comes in as an argument so assigns follow writes
	function automatic logic [79:0] opval(input fpru_pkg::fpru_src_t k, input logic [4:0] i,
		input logic [95:0] r, input logic [79:0] fv, input fpru_pkg::fpru_fmt_t f);
		case (k)
			fpru_pkg::SRC_FP:  opval = fv;
			fpru_pkg::SRC_LIT: opval = i == `FPRU_LIT_ONE ? `FPRU_ONE_VAL : 80'h0;
			default:           opval = widen(r, f);
		endcase
	endfunction

	// Word count of a value held in general registers
	function automatic logic [1:0] words(input fpru_pkg::fpru_fmt_t f);
		words = f == fpru_pkg::FMT_REAL ? 2'h1 : f == fpru_pkg::FMT_LONG ? 2'h2 : 2'h3;
	endfunction

	//------------------------------------------------------------
	// Operation classes
	//------------------------------------------------------------
	// General registers read per opcode variant
	wire is_mov = key == `FPRU_K_MOV || key == `FPRU_K_MOVL || key == `FPRU_K_MOVT;
	wire is_mvr = key == `FPRU_K_MOVR || key == `FPRU_K_MOVRL || key == `FPRU_K_MOVRE;
	wire is_cpy = key == `FPRU_K_CPYS || key == `FPRU_K_CPYRS;
	wire any_fp = kind1 == fpru_pkg::SRC_FP || kind2 == fpru_pkg::SRC_FP || kindd == fpru_pkg::SRC_FP;
	fpru_pkg::fpru_fmt_t gfmt;
	assign gfmt = key == `FPRU_K_MOVRE ? fpru_pkg::FMT_EXT : long_op ? fpru_pkg::FMT_LONG : fpru_pkg::FMT_REAL;
	wire [79:0] opa = opval(kind1, idx1, raw1, fpr[idx1[1:0]], gfmt);
	wire [79:0] opb = opval(kind2, idx2, raw2, fpr[idx2[1:0]], gfmt);

	// Refuse odd operands and anything not routed here
	wire bad = kind1 == fpru_pkg::SRC_BAD || kind2 == fpru_pkg::SRC_BAD || kindd == fpru_pkg::SRC_BAD
		|| kindd == fpru_pkg::SRC_LIT || !(is_mov || is_mvr || is_cpy || arith_op)
		|| (is_mov && (kind1 != fpru_pkg::SRC_GEN || kindd != fpru_pkg::SRC_GEN))
		|| (is_cpy && !any_fp);
	wire accept = st == fpru_pkg::ST_IDLE && ins_valid;
	wire waiting = st == fpru_pkg::ST_WAIT;
	wire fin = waiting && res_valid;
	assign ins_ready = st == fpru_pkg::ST_IDLE;

	//------------------------------------------------------------
	// Rounder feed: real moves now, arithmetic on return
	//------------------------------------------------------------
	// One rounder for both paths keeps a single rounding step
	wire         rnd_sgn  = waiting ? res_sgn : opa[79];
	wire [16:0]  rnd_exp  = waiting ? res_exp : {2'h0, opa[78:64]};
	wire [66:0]  rnd_sig  = waiting ? res_sig : {opa[63:0], 3'h0};
	wire         rnd_pass = waiting ? res_nan || res_exp == 17'h0 : opa[78:64] == 15'h0 || opa[78:64] == 15'h7fff;
	fpru_pkg::fpru_fmt_t rnd_fmt;
	assign rnd_fmt = waiting ? (w_kind == fpru_pkg::SRC_FP ? fpru_pkg::FMT_EXT : w_fmt)
		: (kindd == fpru_pkg::SRC_FP ? fpru_pkg::FMT_EXT : gfmt);
	logic [79:0] rnd_res;
	logic        rnd_inx;
	logic        rnd_ovf;

	fpru_rounder u_rnd (
		.sgn     (rnd_sgn),
		.exp_in  (rnd_exp),
		.sig_in  (rnd_sig),
		.pass    (rnd_pass),
		.fmt     (rnd_fmt),
		.rmode   (ac[`FPRU_AC_RM_HI:`FPRU_AC_RM_LO]),
		.res     (rnd_res),
		.inexact (rnd_inx),
		.ovf     (rnd_ovf)
	);

	//------------------------------------------------------------
	// Write selection
	//------------------------------------------------------------
	logic        wr_en;
	logic        wr_fp;
	logic [4:0]  wr_idx;
	logic [1:0]  wr_n;
	logic [95:0] wr_data;
	logic        set_flags;
	always_comb begin
		wr_en     = 1'b0;
		set_flags = 1'b0;
		wr_fp     = waiting ? w_kind == fpru_pkg::SRC_FP : kindd == fpru_pkg::SRC_FP;
		wr_idx    = waiting ? w_idx : idxd;
		wr_n      = words(rnd_fmt);
		wr_data   = {16'h0, rnd_res};
		if (accept && !bad && is_mov) begin
			wr_en   = 1'b1;
			wr_data = raw1;
			wr_n    = key == `FPRU_K_MOV ? 2'h1 : key == `FPRU_K_MOVL ? 2'h2 : 2'h3;
		end else if (accept && !bad && is_mvr) begin
			wr_en     = 1'b1;
			set_flags = 1'b1;
		end else if (accept && !bad && is_cpy) begin
			wr_en   = 1'b1;
			wr_n    = 2'h3;
			wr_data = {16'h0, opb[79] ^ (key == `FPRU_K_CPYRS), opa[78:0]};
		end else if (fin && !w_cmp) begin
			wr_en     = 1'b1;
			set_flags = 1'b1;
		end
	end

	// Register file; extended values take three words
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < 32; k++)
				gen[k] <= 32'h0;
			for (int k = 0; k < 4; k++)
				fpr[k] <= 80'h0;
		end else if (wr_en && wr_fp) begin
			fpr[wr_idx[1:0]] <= wr_data[79:0];
		end else if (wr_en) begin
			for (int k = 0; k < 3; k++)
				if (k < int'(wr_n))
					gen[5'(wr_idx + 5'(k))] <= wr_data[32*k +: 32];
		end
	end

	//------------------------------------------------------------
	// Control word; hardware flags win over a software write
	//------------------------------------------------------------
	logic [31:0] next_ac;
	always_comb begin
		next_ac = ac_wr ? ac_wdata : ac;
		if (set_flags) begin
			next_ac[`FPRU_AC_INX] = next_ac[`FPRU_AC_INX] | rnd_inx;
			next_ac[`FPRU_AC_OVF] = next_ac[`FPRU_AC_OVF] | rnd_ovf;
		end
		if (fin && w_cmp)
			next_ac[2:0] = res_cc;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			ac <= `FPRU_AC_RST;
		else
			ac <= next_ac;
	end

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------
	// Arithmetic leaves to the outside unit, then comes back here
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st       <= fpru_pkg::ST_IDLE;
			op_start <= 1'b0;
			ins_done <= 1'b0;
			ins_bad  <= 1'b0;
		end else begin
			op_start <= accept && !bad && arith_op;
			ins_bad  <= accept && bad;
			ins_done <= fin || (accept && !bad && !arith_op);
			case (st)
				fpru_pkg::ST_IDLE: st <= accept && !bad && arith_op ? fpru_pkg::ST_WAIT : fpru_pkg::ST_IDLE;
				fpru_pkg::ST_WAIT: st <= res_valid ? fpru_pkg::ST_IDLE : fpru_pkg::ST_WAIT;
				default:           st <= fpru_pkg::ST_IDLE;
			endcase
		end
	end

	// Operands and destination held for the outside unit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			op_a    <= 80'h0;
			op_b    <= 80'h0;
			op_sub  <= 4'h0;
			op_long <= 1'b0;
			w_kind  <= fpru_pkg::SRC_GEN;
			w_idx   <= 5'h0;
			w_fmt   <= fpru_pkg::FMT_REAL;
			w_cmp   <= 1'b0;
		end else if (accept && !bad && arith_op) begin
			op_a    <= opa;
			op_b    <= opb;
			op_sub  <= key[3:0];
			op_long <= long_op;
			w_kind  <= kindd;
			w_idx   <= idxd;
			w_fmt   <= gfmt;
			w_cmp   <= cmp_op;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	wire [63:0] trunc  = rnd_sig[66:3];
	wire        rchk   = set_flags && rnd_fmt == fpru_pkg::FMT_EXT && !rnd_pass && !rnd_ovf;
	wire [1:0]  rm     = ac[`FPRU_AC_RM_HI:`FPRU_AC_RM_LO];
	sequence s_issue;
		accept && !bad && arith_op;
	endsequence
	sequence s_started;
		op_start && waiting;
	endsequence

	chk_inexact_set: assert property (set_flags && rnd_inx |=> ac[`FPRU_AC_INX])
		else $error("inexact flag not set");
	chk_round_up: assert property (rchk && rm == `FPRU_RM_UP && !rnd_sgn && rnd_inx && trunc != 64'hffffffffffffffff
		|-> rnd_res[63:0] == trunc + 64'h1) else $error("round up wrong");
	chk_round_down: assert property (rchk && rm == `FPRU_RM_DOWN && !rnd_sgn |-> rnd_res[63:0] == trunc)
		else $error("round down wrong");
	chk_round_zero: assert property (rchk && rm == `FPRU_RM_ZERO |-> rnd_res[63:0] == trunc)
		else $error("truncate wrong");
	chk_near_low: assert property (rchk && rm == `FPRU_RM_NEAR && !rnd_sig[2] |-> rnd_res[63:0] == trunc)
		else $error("nearest rounded below half up");
	chk_pos_ovf: assert property (set_flags && rnd_ovf && !rnd_sgn && rm == `FPRU_RM_ZERO
		&& rnd_fmt == fpru_pkg::FMT_EXT |-> rnd_res[78:64] == 15'h7ffe) else $error("positive overflow wrong");
	chk_neg_ovf: assert property (set_flags && rnd_ovf && rnd_sgn && rm == `FPRU_RM_DOWN
		&& rnd_fmt == fpru_pkg::FMT_EXT |-> rnd_res[78:64] == 15'h7fff) else $error("negative overflow wrong");
	chk_cmp_exact: assert property (fin && w_cmp && !ac_wr |=> ac[`FPRU_AC_INX] == $past(ac[`FPRU_AC_INX]))
		else $error("compare touched inexact");
	chk_arith_issue: assert property (s_issue |=> s_started ##1 !op_start)
		else $error("arithmetic not issued");
	chk_lit_one: assert property (accept && kind1 == fpru_pkg::SRC_LIT && idx1 == `FPRU_LIT_ONE
		|-> opa == `FPRU_ONE_VAL) else $error("literal one wrong");
endmodule
`default_nettype wire

// *** src/fpru_consts.svh ***
// Constants of the rounding and operand unit
`ifndef FPRU_CONSTS_SVH
`define FPRU_CONSTS_SVH
// Control word fields and reset value
`define FPRU_AC_RST     32'h00000000
`define FPRU_AC_OVF     16
`define FPRU_AC_INX     20
`define FPRU_AC_RM_HI   31
`define FPRU_AC_RM_LO   30
// Rounding-control codes
`define FPRU_RM_NEAR    2'h0
`define FPRU_RM_DOWN    2'h1
`define FPRU_RM_UP      2'h2
`define FPRU_RM_ZERO    2'h3
// Three-operand register format fields
`define FPRU_F_OP       31:24
`define FPRU_F_DST      23:19
`define FPRU_F_SRC2     18:14
`define FPRU_F_M3       13
`define FPRU_F_M2       12
`define FPRU_F_M1       11
`define FPRU_F_SUB      10:7
`define FPRU_F_SRC1     4:0
// Operation keys {major, sub}
`define FPRU_K_MOV      12'h5c0
`define FPRU_K_MOVL     12'h5d0
`define FPRU_K_MOVT     12'h5e0
`define FPRU_K_MOVR     12'h6c0
`define FPRU_K_MOVRL    12'h6d0
`define FPRU_K_MOVRE    12'h6e0
`define FPRU_K_CPYS     12'h6f0
`define FPRU_K_CPYRS    12'h6f1
`define FPRU_MAJ_AR     8'h78
`define FPRU_MAJ_ARL    8'h79
`define FPRU_SUB_CMP    4'h4
// Operand codes with the mode bit set
`define FPRU_FP_CODES   5'h04
`define FPRU_LIT_ZERO   5'h10
`define FPRU_LIT_ONE    5'h16
`define FPRU_ONE_VAL    80'h3fff_8000_0000_0000_0000
// Format geometry; maximum exponents in extended bias, all-ones exponents in the format's own field
`define FPRU_POS_REAL   7'h2b
`define FPRU_POS_LONG   7'h0e
`define FPRU_POS_EXT    7'h03
`define FPRU_RB_REAL    15'h3f80
`define FPRU_RB_LONG    15'h3c00
`define FPRU_RB_EXT     15'h0000
`define FPRU_EMAX_REAL  17'h0407e
`define FPRU_EMAX_LONG  17'h043fe
`define FPRU_EMAX_EXT   17'h07ffe
`define FPRU_EALL_REAL  15'h00ff
`define FPRU_EALL_LONG  15'h07ff
`define FPRU_EALL_EXT   15'h7fff
`endif

// *** src/fpru_pkg.sv ***
// Types of the rounding and operand unit
`default_nettype none
package fpru_pkg;
	typedef enum logic [1:0] {FMT_REAL, FMT_LONG, FMT_EXT} fpru_fmt_t;
	typedef enum logic [1:0] {SRC_GEN, SRC_FP, SRC_LIT, SRC_BAD} fpru_src_t;
	typedef enum logic {ST_IDLE, ST_WAIT} fpru_state_t;
endpackage
`default_nettype wire

// *** src/fpru_opdec.sv ***
// Operand and opcode decoder for the register instruction format
`timescale 1ns/1ps
`default_nettype none
`include "fpru_consts.svh"
module fpru_opdec (
	// Instruction word
	input  wire logic [31:0]         ins_word,
	// Operation
	output logic [11:0]              key,
	output logic                     long_op,
	output logic                     arith_op,
	output logic                     cmp_op,
	// Operands
	output fpru_pkg::fpru_src_t      kind1,
	output fpru_pkg::fpru_src_t      kind2,
	output fpru_pkg::fpru_src_t      kindd,
	output logic [4:0]               idx1,
	output logic [4:0]               idx2,
	output logic [4:0]               idxd
);
	// Mode bit clear: general register; set: fp register or literal
	function automatic fpru_pkg::fpru_src_t op_kind(input logic m, input logic [4:0] f);
		if (!m)
			return fpru_pkg::SRC_GEN;
		if (f < `FPRU_FP_CODES)
			return fpru_pkg::SRC_FP;
		if (f == `FPRU_LIT_ZERO || f == `FPRU_LIT_ONE)
			return fpru_pkg::SRC_LIT;
		return fpru_pkg::SRC_BAD;
	endfunction

	// Field split, same layout for every instruction
	assign key      = {ins_word[`FPRU_F_OP], ins_word[`FPRU_F_SUB]};
	assign long_op  = ins_word[24];
	assign arith_op = ins_word[`FPRU_F_OP] == `FPRU_MAJ_AR || ins_word[`FPRU_F_OP] == `FPRU_MAJ_ARL;
	assign cmp_op   = arith_op && ins_word[`FPRU_F_SUB] == `FPRU_SUB_CMP;
	assign idx1     = ins_word[`FPRU_F_SRC1];
	assign idx2     = ins_word[`FPRU_F_SRC2];
	assign idxd     = ins_word[`FPRU_F_DST];
	assign kind1    = op_kind(ins_word[`FPRU_F_M1], idx1);
	assign kind2    = op_kind(ins_word[`FPRU_F_M2], idx2);
	assign kindd    = op_kind(ins_word[`FPRU_F_M3], idxd);
endmodule
`default_nettype wire

// *** src/fpru_rounder.sv ***
// Single-step rounder to real, long real or extended real
`timescale 1ns/1ps
`default_nettype none
`include "fpru_consts.svh"
module fpru_rounder (
	// Exact value, extended-biased exponent
	input  wire logic                 sgn,
	input  wire logic [16:0]          exp_in,
	input  wire logic [66:0]          sig_in,
	input  wire logic                 pass,
	// Target
	input  wire fpru_pkg::fpru_fmt_t  fmt,
	input  wire logic [1:0]           rmode,
	// Result
	output logic [79:0]               res,
	output logic                      inexact,
	output logic                      ovf
);
	logic [6:0]  pos;
	logic [16:0] emax;
	logic [14:0] rebias;
	logic [14:0] eall;

	// Precision cut and range of the target
	assign pos    = fmt == fpru_pkg::FMT_REAL ? `FPRU_POS_REAL : fmt == fpru_pkg::FMT_LONG ? `FPRU_POS_LONG : `FPRU_POS_EXT;
	assign emax   = fmt == fpru_pkg::FMT_REAL ? `FPRU_EMAX_REAL : fmt == fpru_pkg::FMT_LONG ? `FPRU_EMAX_LONG : `FPRU_EMAX_EXT;
	assign rebias = fmt == fpru_pkg::FMT_REAL ? `FPRU_RB_REAL : fmt == fpru_pkg::FMT_LONG ? `FPRU_RB_LONG : `FPRU_RB_EXT;
	assign eall   = fmt == fpru_pkg::FMT_REAL ? `FPRU_EALL_REAL : fmt == fpru_pkg::FMT_LONG ? `FPRU_EALL_LONG : `FPRU_EALL_EXT;

	// Guard and sticky from the exact bits below the cut
	wire [66:0] kept   = sig_in >> pos;
	wire [66:0] half   = 67'h1 << (pos - 7'h1);
	wire [66:0] below  = half - 67'h1;
	wire        guard  = |(sig_in & half);
	wire        sticky = |(sig_in & below);
	wire        lost   = guard | sticky;

	// Increment decision per mode
	wire bump = !pass && (rmode == `FPRU_RM_NEAR ? guard && (sticky || kept[0]) :
		rmode == `FPRU_RM_UP ? !sgn && lost :
		rmode == `FPRU_RM_DOWN ? sgn && lost : 1'b0);
	wire [66:0] sum   = kept + {66'h0, bump};
	wire [6:0]  prec  = 7'h43 - pos;
	wire        carry = sum[prec];
	wire [66:0] mant  = carry ? sum >> 1 : sum;
	wire [16:0] e_r   = exp_in + {16'h0, carry};

	// Overflow picks infinity or the largest finite value
	wire        to_inf = rmode == `FPRU_RM_NEAR || (rmode == `FPRU_RM_UP && !sgn) || (rmode == `FPRU_RM_DOWN && sgn);
	wire [66:0] m_top  = 67'h1 << (prec - 7'h1);
	wire [66:0] m_max  = (67'h1 << prec) - 67'h1;
	assign ovf     = !pass && e_r > emax;
	assign inexact = !pass && (lost || ovf);
	wire [14:0] e_n = 15'(e_r - {2'h0, rebias});
	wire [14:0] e_o = ovf ? (to_inf ? eall : eall - 15'h1) : pass ? (exp_in == 17'h0 ? 15'h0 : eall) : e_n;
	wire [66:0] m_o = ovf && to_inf ? m_top : ovf ? m_max : mant;

	// Pack into the target layout, low bits first
	always_comb begin
		case (fmt)
			fpru_pkg::FMT_REAL: res = {48'h0, sgn, e_o[7:0], m_o[22:0]};
			fpru_pkg::FMT_LONG: res = {16'h0, sgn, e_o[10:0], m_o[51:0]};
			default:            res = {sgn, e_o, m_o[63:0]};
		endcase
	end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the rounding and operand unit
`timescale 1ns/1ps
`default_nettype none
`include "fpru_consts.svh"
module tb;
	//------------------------------------------------------------
	// Signals
	//------------------------------------------------------------
	logic        core_clk, rst, ins_valid, res_valid, res_sgn, res_nan, ac_wr;
	logic [31:0] ins_word, ac_wdata;
	logic [16:0] res_exp;
	logic [66:0] res_sig;
	logic [2:0]  res_cc;
	wire logic   ins_ready, ins_done, ins_bad, op_start, op_long;
	wire logic [3:0]  op_sub;
	wire logic [79:0] op_a, op_b;
	wire logic [31:0] ac;
	int          fail_count, compares;
	logic [79:0] la, lb, ev;
	fpru_top DUT (.core_clk(core_clk), .rst(rst), .ins_valid(ins_valid), .ins_word(ins_word),
		.ins_ready(ins_ready), .ins_done(ins_done), .ins_bad(ins_bad), .op_start(op_start),
		.op_sub(op_sub), .op_long(op_long), .op_a(op_a), .op_b(op_b), .res_valid(res_valid),
		.res_sgn(res_sgn), .res_exp(res_exp), .res_sig(res_sig), .res_nan(res_nan),
		.res_cc(res_cc), .ac_wr(ac_wr), .ac_wdata(ac_wdata), .ac(ac));
	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic check(input string nm, input logic [79:0] e, input logic [79:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [31:0] mk(input logic [7:0] op, input logic [4:0] d, input logic md,
		input logic [4:0] s2, input logic m2, input logic m1, input logic [3:0] sb, input logic [4:0] s1);
		return {op, d, s2, md, m2, m1, sb, 2'b00, s1};
	endfunction
	// Poll after each edge so a one-cycle pulse is never missed
	task automatic waitfor(input logic st);
		int n;
		n = 0;
		while ((st ? op_start : (ins_done | ins_bad)) !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#2;
			n++;
		end
		if (n == 40) check("handshake", 80'h1, 80'h0);
	endtask
	task automatic issue(input logic [31:0] w);
		int n;
		n = 0;
		// One edge with valid low, so back-to-back calls never retoggle it in one step
		@(posedge core_clk);
		#2;
		while (ins_ready !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#2;
			n++;
		end
		ins_word = w;
		ins_valid = 1'b1;
		@(posedge core_clk);
		#2;
		ins_valid = 1'b0;
	endtask
	task automatic arith(input logic [31:0] w, input logic s, input logic [16:0] e, input logic [66:0] g,
		input logic nan, input logic [2:0] cc);
		issue(w);
		waitfor(1'b1);
		la = op_a;
		lb = op_b;
		check("busy", 80'h0, 80'(ins_ready));
		{res_sgn, res_exp, res_sig, res_nan, res_cc} = {s, e, g, nan, cc};
		res_valid = 1'b1;
		@(posedge core_clk);
		#2;
		res_valid = 1'b0;
		res_exp = ~res_exp;
		res_sig = ~res_sig;
		waitfor(1'b0);
	endtask
	// Register contents show up as operand a of a real add into fp3; real and long real never mixed
	task automatic read_reg(input logic [4:0] c, input logic m);
		arith(mk(8'h78, 5'h03, 1'b1, 5'h10, 1'b1, m, 4'h0, c), 1'b0, 17'h0, 67'h0, 1'b0, 3'h0);
	endtask
	task automatic set_mode(input logic [1:0] rm);
		ac_wdata = {rm, 30'h0};
		ac_wr = 1'b1;
		@(posedge core_clk);
		#2;
		ac_wr = 1'b0;
		check("round mode", 80'(rm), 80'(ac[31:30]));
	endtask
	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_literals();
		arith(mk(8'h79, 5'h03, 1'b1, 5'h10, 1'b1, 1'b1, 4'h0, 5'h16), 1'b0, 17'h0, 67'h0, 1'b0, 3'h0);
		check("literal one", `FPRU_ONE_VAL, la);
		check("literal zero", 80'h0, lb);
		check("long variant", 80'h1, 80'(op_long));
	endtask
	task automatic t_round();
		logic [2:0] gt [4];
		logic       lsb, inc;
		gt = '{3'b100, 3'b100, 3'b011, 3'b000};
		for (int rm = 0; rm < 4; rm++) begin
			for (int s = 0; s < 2; s++) begin
				for (int c = 0; c < 4; c++) begin
					lsb = (c == 1);
					set_mode(2'(rm));
					arith(mk(8'h78, 5'h00, 1'b1, 5'h10, 1'b1, 1'b1, 4'h0, 5'h10), 1'(s), 17'h03fff,
						{1'b1, 62'h0, lsb, gt[c]}, 1'b0, 3'h0);
					check("inexact", 80'(gt[c] != 3'b000), 80'(ac[20]));
					// Expected increment worked out per mode, sign and guard bits
					inc = (gt[c] == 3'b000) ? 1'b0 : (rm == 0) ? (gt[c][2] && (gt[c][1:0] != 2'b00 || lsb))
						: (rm == 2) ? (s == 0) : (rm == 1) ? (s == 1) : 1'b0;
					read_reg(5'h00, 1'b1);
					check("rounded", {1'(s), 15'h3fff, ({1'b1, 62'h0, lsb} + 64'(inc))}, la);
				end
			end
		end
	endtask
	task automatic t_overflow();
		logic inf;
		for (int rm = 0; rm < 4; rm++) begin
			for (int s = 0; s < 2; s++) begin
				set_mode(2'(rm));
				arith(mk(8'h78, 5'h00, 1'b1, 5'h10, 1'b1, 1'b1, 4'h0, 5'h10), 1'(s), 17'h08000,
					{1'b1, 66'h0}, 1'b0, 3'h0);
				check("overflow flag", 80'h1, 80'(ac[16]));
				inf = (rm == 0) || (rm == 2 && s == 0) || (rm == 1 && s == 1);
				ev = inf ? {1'(s), 15'h7fff, 64'h8000_0000_0000_0000} : {1'(s), 15'h7ffe, {64{1'b1}}};
				read_reg(5'h00, 1'b1);
				check("overflow value", ev, la);
			end
		end
	endtask
	// Sticky only at the bottom: one rounding goes up, two roundings would tie down
	task automatic t_narrow();
		set_mode(`FPRU_RM_NEAR);
		arith(mk(8'h78, 5'h13, 1'b0, 5'h10, 1'b1, 1'b1, 4'h0, 5'h10), 1'b0, 17'h03fff,
			{24'h800000, 1'b1, 41'h0, 1'b1}, 1'b0, 3'h0);
		check("narrow inexact", 80'h1, 80'(ac[20]));
		ev = {1'b0, 15'h3fff, 24'h800001, 40'h0};
		read_reg(5'h13, 1'b0);
		check("narrow value", ev, la);
	endtask
	task automatic t_moves();
		logic [31:0] w [4];
		logic [79:0] e [4];
		logic [4:0]  rd [4];
		w = '{mk(8'h6c, 5'h01, 1'b1, 5'h0, 1'b0, 1'b0, 4'h0, 5'h13), mk(8'h6f, 5'h02, 1'b1, 5'h16, 1'b1, 1'b1, 4'h1, 5'h01),
			mk(8'h6f, 5'h02, 1'b1, 5'h16, 1'b1, 1'b1, 4'h0, 5'h02), mk(8'h5c, 5'h06, 1'b0, 5'h0, 1'b0, 1'b0, 4'h0, 5'h13)};
		e = '{ev, {1'b1, ev[78:0]}, ev, ev};
		rd = '{5'h01, 5'h02, 5'h02, 5'h06};
		for (int i = 0; i < 4; i++) begin
			issue(w[i]);
			waitfor(1'b0);
			check("move done", 80'h1, 80'(ins_done));
			read_reg(rd[i], i < 3);
			check("moved value", e[i], la);
		end
	endtask
	task automatic t_refuse();
		logic [31:0] w [5];
		w = '{mk(8'h6f, 5'h05, 1'b0, 5'h0, 1'b0, 1'b0, 4'h0, 5'h13), mk(8'h5c, 5'h05, 1'b0, 5'h0, 1'b0, 1'b1, 4'h0, 5'h00),
			mk(8'h6c, 5'h10, 1'b1, 5'h0, 1'b0, 1'b0, 4'h0, 5'h13), mk(8'h78, 5'h03, 1'b1, 5'h10, 1'b1, 1'b1, 4'h0, 5'h05),
			mk(8'h00, 5'h03, 1'b1, 5'h10, 1'b1, 1'b1, 4'h0, 5'h10)};
		for (int i = 0; i < 5; i++) begin
			issue(w[i]);
			waitfor(1'b0);
			check("refused", 80'h1, 80'(ins_bad));
		end
	endtask
	task automatic t_unrounded();
		set_mode(`FPRU_RM_UP);
		arith(mk(8'h78, 5'h03, 1'b1, 5'h10, 1'b1, 1'b1, 4'h4, 5'h16), 1'b0, 17'h03fff, {1'b1, 63'h0, 3'b101}, 1'b0, 3'h2);
		check("compare code", 80'h2, 80'(ac[2:0]));
		check("sub opcode", 80'h4, 80'(op_sub));
		check("compare inexact", 80'h0, 80'(ac[20]));
		arith(mk(8'h78, 5'h03, 1'b1, 5'h10, 1'b1, 1'b1, 4'h0, 5'h16), 1'b0, 17'h07fff, {2'b11, 62'h0, 3'b101}, 1'b1, 3'h0);
		check("nan inexact", 80'h0, 80'(ac[20]));
	endtask
	//------------------------------------------------------------
	// Run control
	//------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Whole run is a few hundred cycles; cut a hang well beyond that
	initial begin
		#400000;
		fail_count++;
		complete_run();
	end
	initial begin
		{rst, ins_valid, res_valid, res_sgn, res_nan, ac_wr} = 6'b100000;
		{ins_word, ac_wdata, res_exp, res_sig, res_cc} = '0;
		fail_count = 0;
		compares = 0;
		repeat (3) @(posedge core_clk);
		#2;
		rst = 1'b0;
		t_literals();
		t_round();
		t_overflow();
		t_narrow();
		t_moves();
		t_refuse();
		t_unrounded();
		complete_run();
	end
endmodule
`default_nettype wire
